// [hw/bfl_backlight_fade_level_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "bfl_cfg.svh"

module bfl_backlight_fade_level_regs
  import bfl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `BFL_TICK_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wr_data,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rd_data,
  output logic            reg_rd_valid,
  input  wire logic       backlight_turn_on_bit,
  input  wire logic       backlight_dim_active,
  input  wire logic       automatic_level_follow,
  input  wire logic [1:0] host_level_select,
  input  wire logic       office_cmp_out,
  input  wire logic       dark_cmp_out,
  output logic      [1:0] ambient_level_select,
  output logic      [6:0] live_sink_code,
  output logic            fade_busy
);

  ////////////////////////////////////////////////////////////////////////////
  // duration of a fade code in 0.1 s units
  function automatic logic [5:0] fade_units(input logic [3:0] code);
    logic [5:0] units;
    if (code <= `BFL_FADE_KNEE_CODE) begin
      units = 6'(code * `BFL_SHORT_UNITS);
    end else begin
      units = 6'(`BFL_FADE_KNEE_CODE * `BFL_SHORT_UNITS + (code - `BFL_FADE_KNEE_CODE) * `BFL_LONG_UNITS);
    end
    return units;
  endfunction : fade_units

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0] fade_duration_pair_reg,     fade_duration_pair_next;
  logic [6:0] bright_level_peak_code_reg, bright_level_peak_code_next;
  logic [6:0] bright_level_low_code_reg,  bright_level_low_code_next;
  logic [6:0] indoor_level_peak_code_reg, indoor_level_peak_code_next;
  logic [6:0] indoor_level_low_code_reg,  indoor_level_low_code_next;
  logic [6:0] night_level_peak_code_reg,  night_level_peak_code_next;
  logic [6:0] night_level_low_code_reg,   night_level_low_code_next;
  logic [7:0] rd_data_reg,                rd_data_next;
  logic       rd_valid_reg;

  always_comb begin
    fade_duration_pair_next     = fade_duration_pair_reg;
    bright_level_peak_code_next = bright_level_peak_code_reg;
    bright_level_low_code_next  = bright_level_low_code_reg;
    indoor_level_peak_code_next = indoor_level_peak_code_reg;
    indoor_level_low_code_next  = indoor_level_low_code_reg;
    night_level_peak_code_next  = night_level_peak_code_reg;
    night_level_low_code_next   = night_level_low_code_reg;
    if (reg_wr_en) begin
      // bit seven is simply not stored for the code registers
      case (reg_addr)
        `BFL_ADDR_FADE_PAIR:   fade_duration_pair_next     = reg_wr_data;
        `BFL_ADDR_BRIGHT_PEAK: bright_level_peak_code_next = reg_wr_data[`BFL_CODE_MSB:0];
        `BFL_ADDR_BRIGHT_LOW:  bright_level_low_code_next  = reg_wr_data[`BFL_CODE_MSB:0];
        `BFL_ADDR_INDOOR_PEAK: indoor_level_peak_code_next = reg_wr_data[`BFL_CODE_MSB:0];
        `BFL_ADDR_INDOOR_LOW:  indoor_level_low_code_next  = reg_wr_data[`BFL_CODE_MSB:0];
        `BFL_ADDR_NIGHT_PEAK:  night_level_peak_code_next  = reg_wr_data[`BFL_CODE_MSB:0];
        `BFL_ADDR_NIGHT_LOW:   night_level_low_code_next   = reg_wr_data[`BFL_CODE_MSB:0];
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    rd_data_next = rd_data_reg;
    if (reg_rd_en) begin
      case (reg_addr)
        `BFL_ADDR_FADE_PAIR:   rd_data_next = fade_duration_pair_reg;
        `BFL_ADDR_BRIGHT_PEAK: rd_data_next = {1'b0, bright_level_peak_code_reg};
        `BFL_ADDR_BRIGHT_LOW:  rd_data_next = {1'b0, bright_level_low_code_reg};
        `BFL_ADDR_INDOOR_PEAK: rd_data_next = {1'b0, indoor_level_peak_code_reg};
        `BFL_ADDR_INDOOR_LOW:  rd_data_next = {1'b0, indoor_level_low_code_reg};
        `BFL_ADDR_NIGHT_PEAK:  rd_data_next = {1'b0, night_level_peak_code_reg};
        `BFL_ADDR_NIGHT_LOW:   rd_data_next = {1'b0, night_level_low_code_reg};
        `BFL_ADDR_LIVE_SINK:   rd_data_next = {1'b0, live_sink_code};
        default:               rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      fade_duration_pair_reg     <= `BFL_RST_FADE_PAIR;
      bright_level_peak_code_reg <= `BFL_RST_CODE;
      bright_level_low_code_reg  <= `BFL_RST_CODE;
      indoor_level_peak_code_reg <= `BFL_RST_CODE;
      indoor_level_low_code_reg  <= `BFL_RST_CODE;
      night_level_peak_code_reg  <= `BFL_RST_CODE;
      night_level_low_code_reg   <= `BFL_RST_CODE;
      rd_data_reg                <= 8'h00;
      rd_valid_reg               <= 1'b0;
    end else begin
      fade_duration_pair_reg     <= fade_duration_pair_next;
      bright_level_peak_code_reg <= bright_level_peak_code_next;
      bright_level_low_code_reg  <= bright_level_low_code_next;
      indoor_level_peak_code_reg <= indoor_level_peak_code_next;
      indoor_level_low_code_reg  <= indoor_level_low_code_next;
      night_level_peak_code_reg  <= night_level_peak_code_next;
      night_level_low_code_reg   <= night_level_low_code_next;
      rd_data_reg                <= rd_data_next;
      rd_valid_reg               <= reg_rd_en;
    end
  end

  assign reg_rd_data  = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // level selection and target code
  logic [1:0] level_reg, level_next;
  logic [6:0] target_code;

  always_comb begin
    if (automatic_level_follow) begin
      // darker comparator wins when both have tripped
      if (dark_cmp_out) begin
        level_next = BFL_LVL_NIGHT;
      end else if (office_cmp_out) begin
        level_next = BFL_LVL_INDOOR;
      end else begin
        level_next = BFL_LVL_BRIGHT;
      end
    end else begin
      level_next = host_level_select;
    end
  end

  always_comb begin
    target_code = 7'h00;
    if (backlight_turn_on_bit) begin
      case (level_reg)
        BFL_LVL_INDOOR: target_code = backlight_dim_active ? indoor_level_low_code_reg : indoor_level_peak_code_reg;
        BFL_LVL_NIGHT:  target_code = backlight_dim_active ? night_level_low_code_reg : night_level_peak_code_reg;
        // code 11 is undefined and falls back to daylight
        default:        target_code = backlight_dim_active ? bright_level_low_code_reg : bright_level_peak_code_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fade engine: one code per (duration units) ticks, so a full-scale ramp takes the programmed time
  bfl_fade_state_type state_reg,     state_next;
  logic [16:0]        prescale_reg,  prescale_next;
  logic [5:0]         step_cnt_reg,  step_cnt_next;
  logic [6:0]         live_reg,      live_next;
  logic               tick;
  logic               rising;
  logic [3:0]         fade_code;
  logic [5:0]         fade_len;

  assign tick      = (prescale_reg == 17'(TICK_CYCLES - 1));
  assign rising    = (target_code > live_reg);
  assign fade_code = rising ? fade_duration_pair_reg[`BFL_FADE_UP_MSB:`BFL_FADE_UP_LSB]
                            : fade_duration_pair_reg[`BFL_FADE_DOWN_MSB:`BFL_FADE_DOWN_LSB];
  assign fade_len  = fade_units(fade_code);

  always_comb begin
    state_next    = state_reg;
    prescale_next = tick ? 17'h00000 : prescale_reg + 17'h00001;
    step_cnt_next = step_cnt_reg;
    live_next     = live_reg;
    case (state_reg)
      BFL_ST_HOLD: begin
        step_cnt_next = 6'h00;
        if (target_code != live_reg) begin
          if (fade_code == 4'h0) begin
            live_next = target_code;
          end else begin
            state_next = BFL_ST_RAMP;
          end
        end
      end
      BFL_ST_RAMP: begin
        if (target_code == live_reg) begin
          state_next = BFL_ST_HOLD;
        end else if (fade_code == 4'h0) begin
          // fade disabled mid-ramp: jump straight to the target
          live_next  = target_code;
          state_next = BFL_ST_HOLD;
        end else if (tick) begin
          if (step_cnt_reg + 6'h01 >= fade_len) begin
            step_cnt_next = 6'h00;
            live_next     = rising ? live_reg + 7'h01 : live_reg - 7'h01;
          end else begin
            step_cnt_next = step_cnt_reg + 6'h01;
          end
        end
      end
      default: begin
        state_next = BFL_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg    <= BFL_ST_HOLD;
      prescale_reg <= 17'h00000;
      step_cnt_reg <= 6'h00;
      live_reg     <= `BFL_RST_CODE;
      level_reg    <= BFL_LVL_BRIGHT;
    end else begin
      state_reg    <= state_next;
      prescale_reg <= prescale_next;
      step_cnt_reg <= step_cnt_next;
      live_reg     <= live_next;
      level_reg    <= level_next;
    end
  end

  assign live_sink_code       = live_reg;
  assign ambient_level_select = level_reg;
  assign fade_busy            = (state_reg == BFL_ST_RAMP);

endmodule : bfl_backlight_fade_level_regs

`default_nettype wire

// [include/bfl_cfg.svh]
`ifndef BFL_CFG_SVH
`define BFL_CFG_SVH

// register byte offsets
`define BFL_ADDR_FADE_PAIR      8'h04
`define BFL_ADDR_BRIGHT_PEAK    8'h05
`define BFL_ADDR_BRIGHT_LOW     8'h06
`define BFL_ADDR_INDOOR_PEAK    8'h07
`define BFL_ADDR_INDOOR_LOW     8'h08
`define BFL_ADDR_NIGHT_PEAK     8'h09
`define BFL_ADDR_NIGHT_LOW      8'h0a
`define BFL_ADDR_LIVE_SINK      8'h0b

// field positions
`define BFL_FADE_DOWN_MSB       7
`define BFL_FADE_DOWN_LSB       4
`define BFL_FADE_UP_MSB         3
`define BFL_FADE_UP_LSB         0
`define BFL_CODE_MSB            6

// reset values
`define BFL_RST_FADE_PAIR       8'h00
`define BFL_RST_CODE            7'h00

// fade timing: codes 1..10 step 0.3 s up to 3.0 s, then 0.5 s steps
`define BFL_FADE_STEP_SHORT_MS  300
`define BFL_FADE_STEP_LONG_MS   500
`define BFL_FADE_KNEE_CODE      4'ha
`define BFL_FADE_UNIT_MS        100
`define BFL_CLK_PERIOD_NS       10
`define BFL_CODE_STEPS          128
// one fade tick = one 0.1 s duration unit spread over the full code range
`define BFL_TICK_CYCLES         ((`BFL_FADE_UNIT_MS * 1000000) / `BFL_CLK_PERIOD_NS / `BFL_CODE_STEPS)
`define BFL_SHORT_UNITS         (`BFL_FADE_STEP_SHORT_MS / `BFL_FADE_UNIT_MS)
`define BFL_LONG_UNITS          (`BFL_FADE_STEP_LONG_MS / `BFL_FADE_UNIT_MS)

`endif

// [include/bfl_pkg.sv]
package bfl_pkg;

  typedef enum logic [1:0] {
    BFL_LVL_BRIGHT = 2'b00,
    BFL_LVL_INDOOR = 2'b01,
    BFL_LVL_NIGHT  = 2'b10
  } bfl_level_type;

  typedef enum logic [1:0] {
    BFL_ST_HOLD = 2'b01,
    BFL_ST_RAMP = 2'b10
  } bfl_fade_state_type;

endpackage : bfl_pkg

// [sim/bfl_regs_props.sv]
`timescale 1ns/10ps
`default_nettype none
module bfl_regs_props #(
  parameter int unsigned TICK_CYCLES = 4
) (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  input wire logic       reg_rd_valid,
  input wire logic       automatic_level_follow,
  input wire logic [1:0] host_level_select,
  input wire logic       office_cmp_out,
  input wire logic       dark_cmp_out,
  input wire logic [1:0] ambient_level_select,
  input wire logic [6:0] live_sink_code,
  input wire logic       fade_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rd_valid; reg_rd_en |=> reg_rd_valid; endproperty
  property p_no_valid; !reg_rd_en |=> !reg_rd_valid; endproperty
  property p_bit7; reg_rd_en && reg_addr inside {[8'h05:8'h0b]} |=> !reg_rd_data[7]; endproperty
  property p_unmapped; reg_rd_en && !(reg_addr inside {[8'h04:8'h0b]}) |=> reg_rd_data == 8'h00; endproperty
  property p_live_rd; reg_rd_en && reg_addr == 8'h0b |=> reg_rd_data == {1'b0, $past(live_sink_code)}; endproperty
  property p_hold; !reg_rd_en |=> $stable(reg_rd_data); endproperty
  // host code is registered as written; code 11 only picks the daylight codes further on
  property p_host_lvl;
    !automatic_level_follow |=> ambient_level_select == $past(host_level_select);
  endproperty
  // dark comparator has priority over office
  property p_auto_lvl;
    automatic_level_follow |=> ambient_level_select ==
      ($past(dark_cmp_out) ? 2'b10 : ($past(office_cmp_out) ? 2'b01 : 2'b00));
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("read valid missing");
  a_no_valid: assert property (p_no_valid) else $error("stray read valid");
  a_bit7: assert property (p_bit7) else $error("code bit seven set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_live_rd: assert property (p_live_rd) else $error("live code readback wrong");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_host_lvl: assert property (p_host_lvl) else $error("host level not applied");
  a_auto_lvl: assert property (p_auto_lvl) else $error("comparator level wrong");
  c_live_rd: cover property (reg_rd_en && reg_addr == 8'h0b);
  c_auto_dark: cover property (automatic_level_follow && dark_cmp_out);
  c_busy: cover property ($rose(fade_busy));
endmodule : bfl_regs_props
bind bfl_backlight_fade_level_regs bfl_regs_props #(.TICK_CYCLES(TICK_CYCLES)) i_bfl_regs_props (
  .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_rd_en(reg_rd_en),
  .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .automatic_level_follow(automatic_level_follow),
  .host_level_select(host_level_select), .office_cmp_out(office_cmp_out), .dark_cmp_out(dark_cmp_out),
  .ambient_level_select(ambient_level_select), .live_sink_code(live_sink_code), .fade_busy(fade_busy));
`default_nettype wire

// [sim/bfl_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module bfl_host_model (
  input  wire logic       ref_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wr_data,
  output logic            reg_rd_en
);
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  // released lines show the inverse so a stale value cannot pass as a match
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = wr;
    reg_rd_en = !wr;
    @(posedge ref_clk);
    #1;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask : xfer
endmodule : bfl_host_model
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bfl_pkg::*;
  localparam int unsigned TICKS = 4;
  logic       ref_clk, srst, reg_wr_en, reg_rd_en, reg_rd_valid, on, dim, auto, office, dark, fade_busy;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data, e, rd_exp;
  logic [1:0] host_lvl, amb;
  logic [6:0] live;
  logic [7:0] mem [16];
  logic [7:0] q [$];
  int         n_errors, check_count;
  bfl_backlight_fade_level_regs #(.TICK_CYCLES(TICKS)) i_bfl_backlight_fade_level_regs (
    .ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .backlight_turn_on_bit(on),
    .backlight_dim_active(dim), .automatic_level_follow(auto), .host_level_select(host_lvl),
    .office_cmp_out(office), .dark_cmp_out(dark), .ambient_level_select(amb), .live_sink_code(live),
    .fade_busy(fade_busy));
  bfl_host_model i_bfl_host_model (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_bfl_host_model.xfer(1'b1, a, d);
    if (a >= 8'h04 && a <= 8'h0a) mem[a] = (a == 8'h04) ? d : (d & 8'h7f);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    q.push_back(x);
    i_bfl_host_model.xfer(1'b0, a, 8'h00);
  endtask : rd
  function automatic logic [7:0] exp_of(input int a);
    return (a >= 4 && a <= 10) ? mem[a] : 8'h00;
  endfunction : exp_of
  // constant slope: 32 codes take a quarter of the programmed full-scale time
  task automatic fade(input logic up, input logic [3:0] c);
    int n, units, slack;
    logic seen_busy;
    units = (c <= 10) ? 3 * c : 30 + 5 * (c - 10);
    slack = units * TICKS + 8;
    n = 0;
    seen_busy = 1'b0;
    on = up;
    while (live !== (up ? 7'h20 : 7'h00) && n < 20000) begin
      @(posedge ref_clk);
      #1;
      n++;
      seen_busy |= fade_busy;
    end
    if (n >= 20000) begin
      n_errors++;
      summarize();
    end
    check({15'h0, (n >= 32 * units * TICKS - slack) && (n <= 32 * units * TICKS + slack)}, 16'h1, "fade time");
    repeat (2) @(posedge ref_clk);
    #1;
    check({15'h0, seen_busy}, 16'h1, "fade busy seen");
    check({15'h0, fade_busy}, 16'h0, "fade busy after");
  endtask : fade
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    #2;
    if (reg_rd_valid === 1'b1) begin
      rd_exp = (q.size() > 0) ? q.pop_front() : 8'hxx;
      check({8'h0, reg_rd_data}, {8'h0, rd_exp}, "read data");
    end
  end
  initial begin
    {on, dim, auto, office, dark} = 5'h00;
    host_lvl = 2'b00;
    srst = 1'b1;
    foreach (mem[i]) mem[i] = 8'h00;
    void'($urandom(32'h3593));
    repeat (12) @(posedge ref_clk);
    #1;
    srst = 1'b0;
    for (int a = 3; a < 13; a++) rd(8'(a), 8'h00);
    for (int a = 3; a < 13; a++) wr(8'(a), 8'($urandom()));
    for (int a = 3; a < 13; a++) rd(8'(a), exp_of(a));
    $display("test registers done");
    wr(8'h04, 8'h00);
    on = 1'b1;
    for (int l = 0; l < 4; l++) begin
      for (int d = 0; d < 2; d++) begin
        host_lvl = 2'(l);
        dim = d[0];
        repeat (3) @(posedge ref_clk);
        #1;
        e = mem[(l == 3 ? 5 : 5 + 2 * l) + d];
        check({9'h0, live}, {8'h0, e}, "live code");
        rd(8'h0b, e);
      end
    end
    $display("test levels done");
    auto = 1'b1;
    host_lvl = 2'b00;
    for (int k = 0; k < 4; k++) begin
      {dark, office} = 2'(k);
      repeat (2) @(posedge ref_clk);
      #1;
      check({14'h0, amb}, k[1] ? 16'h2 : {15'h0, k[0]}, "level");
    end
    {auto, dim, office, dark} = 4'h0;
    $display("test follow done");
    wr(8'h05, 8'h20);
    repeat (3) @(posedge ref_clk);
    #1;
    wr(8'h04, 8'h21);
    fade(1'b0, 4'h2);
    fade(1'b1, 4'h1);
    wr(8'h04, 8'hbf);
    fade(1'b0, 4'hb);
    fade(1'b1, 4'hf);
    $display("test fades done");
    repeat (4) @(posedge ref_clk);
    check(16'(q.size()), 16'h0, "pending reads");
    summarize();
  end
endmodule : tb
`default_nettype wire
